// ==== core/pds_pkg.sv ====
// Package: constants and types for the parameter dictionary and system time block
package pds_pkg;
  localparam logic [15:0] PDS_IDX_IDENT = 16'h1000;
  localparam logic [15:0] PDS_IDX_LEGACY = 16'h4000;
  localparam logic [15:0] PDS_IDX_INPUT = 16'h6000;
  localparam logic [15:0] PDS_IDX_OUTPUT = 16'h7000;
  localparam logic [15:0] PDS_IDX_CHAN = 16'h8000;
  localparam logic [15:0] PDS_IDX_SUPPRESS = 16'hF008;
  localparam logic [15:0] PDS_CHAN_STRIDE = 16'h0010;
  localparam logic [15:0] PDS_RANGE_MASK = 16'hF000;
  localparam logic [31:0] PDS_SUPPRESS_CODE = 32'h12345678;
  localparam logic [31:0] PDS_ZERO_WORD = 32'h00000000;
  localparam logic [7:0] PDS_SUB_ZERO = 8'h00;
  localparam logic [7:0] PDS_SUB_ONE = 8'h01;
  localparam logic [7:0] PDS_SUB_TWO = 8'h02;
  localparam logic [7:0] PDS_SUB_THREE = 8'h03;
  localparam logic [7:0] PDS_SUB_FOUR = 8'h04;
  localparam int PDS_CLK_PERIOD_NS = 10;
  // Result codes of one access
  typedef enum logic [1:0] {
    PDS_RES_OK = 2'b00,
    PDS_RES_NO_ENTRY = 2'b01,
    PDS_RES_READ_ONLY = 2'b10
  } pds_res_t;
  // Dictionary access states
  typedef enum logic [1:0] {
    PDS_ST_IDLE = 2'b00,
    PDS_ST_COMMIT = 2'b01,
    PDS_ST_WAIT = 2'b10
  } pds_state_t;
endpackage

// ==== core/pds_time.sv ====
// System time counter: nanosecond count with master offset correction
module pds_time
  import pds_pkg::*;
#(
  parameter int TIME_WIDTH = 64,
  parameter int STEP_NS = PDS_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic offset_valid,
  input wire logic [63:0] offset_ns,
  output logic [63:0] sys_time
);
  initial begin
    if (TIME_WIDTH != 64 && TIME_WIDTH != 32) $error("TIME_WIDTH must be 32 or 64");
    if (STEP_NS < 1) $error("STEP_NS must be at least 1");
  end

  localparam logic [TIME_WIDTH-1:0] STEP = TIME_WIDTH'(STEP_NS);
  logic [TIME_WIDTH-1:0] count;
  logic [TIME_WIDTH-1:0] next_count;

  always_comb begin
    next_count = count + STEP;
    if (offset_valid) begin
      next_count = count + STEP + offset_ns[TIME_WIDTH-1:0];
    end
  end

  // zero at reset means epoch start
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // upper bits zero for 32-bit variant, which wraps
  assign sys_time = 64'(count);

  a_time_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !offset_valid |=> count == $past(count) + STEP)
    else $error("system time did not advance by one step");
endmodule

// ==== core/pds_dict.sv ====
// Parameter dictionary with channel blocks, storage suppression and system time
// Notes on behaviour
// - Entries keyed by 16-bit index, 8-bit subindex
// - Fixed entries read only, others writable
// - Identity information at 0x1000 range
// - Channel parameters at 0x8000 range
// - Legacy 0x4000 range mirrors channel parameters
// - Inputs at 0x6000, outputs at 0x7000
// - Channel n block at base plus n*0x10
// - Online changes committed to non-volatile storage
// - Code word at 0xF008 enables suppression
// - Suppression holds while code kept; off at power-up
// - Suppressed changes skip non-volatile storage
// - 64-bit nanosecond system time
// - Time zero is start of year 2000
// - 32-bit variant wraps to zero
module pds_dict
  import pds_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter int SUBS = 4,
  parameter int TIME_WIDTH = 64,
  parameter logic [31:0] ID_VENDOR = 32'h0000A5A5,
  parameter logic [31:0] ID_PRODUCT = 32'h00001234,
  parameter logic [31:0] ID_SERIAL = 32'h00000001
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0] req_sub,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic [1:0] rsp_code,
  output logic [31:0] rsp_rdata,
  output logic req_busy,
  output logic nv_write,
  output logic [15:0] nv_index,
  output logic [7:0] nv_sub,
  output logic [31:0] nv_data,
  input wire logic nv_done,
  output logic storage_suppress_mode,
  input wire logic [31:0] in_obj [CHANNELS],
  output logic [31:0] out_obj [CHANNELS],
  input wire logic time_offset_valid,
  input wire logic [63:0] time_offset_ns,
  output logic [63:0] sys_time
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS must be 1 to 16");
    if (SUBS < 1 || SUBS > 255) $error("SUBS must be 1 to 255");
  end

  localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
  localparam int SW = (SUBS > 1) ? $clog2(SUBS) : 1;

  // Channel parameter store and output objects
  logic [31:0] param [CHANNELS][SUBS];
  logic [31:0] next_param [CHANNELS][SUBS];
  logic [31:0] next_out_obj [CHANNELS];
  logic [31:0] suppress_word;
  logic [31:0] next_suppress_word;
  pds_state_t state;
  pds_state_t next_state;
  logic next_rsp_valid;
  logic [1:0] next_rsp_code;
  logic [31:0] next_rsp_rdata;
  logic next_nv_write;
  logic [15:0] next_nv_index;
  logic [7:0] next_nv_sub;
  logic [31:0] next_nv_data;

  // Decode of the request key
  logic [15:0] range_base;
  logic [15:0] range_off;
  logic [11:0] chan_raw;
  logic [3:0] idx_low;
  logic chan_ok;
  logic sub_ok;
  logic [CW-1:0] chan;
  logic [SW-1:0] sub;
  logic is_param;
  logic is_ident;
  logic is_in;
  logic is_out;
  logic is_supp;

  always_comb begin
    range_base = req_index & PDS_RANGE_MASK;
    range_off = req_index - range_base;
    chan_raw = range_off[15:4];
    idx_low = range_off[3:0];
    chan_ok = (32'(chan_raw) < CHANNELS);
    sub_ok = (32'(req_sub) < SUBS);
    chan = CW'(chan_raw);
    sub = SW'(req_sub);
    is_param = 1'b0;
    is_ident = 1'b0;
    is_in = 1'b0;
    is_out = 1'b0;
    is_supp = 1'b0;
    if (req_index == PDS_IDX_SUPPRESS) begin
      is_supp = req_sub == PDS_SUB_ZERO;
    // channel range and legacy mirror share one store
    end else if (range_base == PDS_IDX_CHAN || range_base == PDS_IDX_LEGACY) begin
      is_param = chan_ok && idx_low == 4'h0 && sub_ok;
    end else if (range_base == PDS_IDX_INPUT) begin
      is_in = chan_ok && idx_low == 4'h0 && req_sub == PDS_SUB_ONE;
    end else if (range_base == PDS_IDX_OUTPUT) begin
      is_out = chan_ok && idx_low == 4'h0 && req_sub == PDS_SUB_ONE;
    end else if (req_index == PDS_IDX_IDENT) begin
      is_ident = req_sub <= PDS_SUB_FOUR;
    end
  end

  // Identity read data
  logic [31:0] ident_data;
  always_comb begin
    case (req_sub)
      PDS_SUB_ZERO: ident_data = 32'(PDS_SUB_FOUR);
      PDS_SUB_ONE: ident_data = ID_VENDOR;
      PDS_SUB_TWO: ident_data = ID_PRODUCT;
      PDS_SUB_THREE: ident_data = ID_SERIAL;
      default: ident_data = 32'(CHANNELS);
    endcase
  end

  // Next state of the access machine
  always_comb begin
    next_state = state;
    next_param = param;
    next_out_obj = out_obj;
    next_suppress_word = suppress_word;
    next_rsp_valid = 1'b0;
    next_rsp_code = rsp_code;
    next_rsp_rdata = rsp_rdata;
    next_nv_write = 1'b0;
    next_nv_index = nv_index;
    next_nv_sub = nv_sub;
    next_nv_data = nv_data;
    case (state)
      PDS_ST_IDLE: begin
        if (req_valid) begin
          next_rsp_valid = 1'b1;
          next_rsp_code = PDS_RES_OK;
          next_rsp_rdata = PDS_ZERO_WORD;
          if (is_supp) begin
            if (req_write) begin
              next_suppress_word = req_wdata;
            end
            next_rsp_rdata = suppress_word;
          end else if (is_param) begin
            next_rsp_rdata = param[chan][sub];
            if (req_write) begin
              next_param[chan][sub] = req_wdata;
              if (!storage_suppress_mode) begin
                next_nv_write = 1'b1;
                next_nv_index = PDS_IDX_CHAN + (req_index - range_base);
                next_nv_sub = req_sub;
                next_nv_data = req_wdata;
                next_rsp_valid = 1'b0;
                next_state = PDS_ST_COMMIT;
              end
            end
          end else if (is_out) begin
            next_rsp_rdata = out_obj[chan];
            if (req_write) begin
              next_out_obj[chan] = req_wdata;
            end
          end else if (is_in || is_ident) begin
            next_rsp_rdata = is_in ? in_obj[chan] : ident_data;
            if (req_write) begin
              next_rsp_code = PDS_RES_READ_ONLY;
            end
          end else begin
            next_rsp_code = PDS_RES_NO_ENTRY;
          end
        end
      end
      PDS_ST_COMMIT: begin
        next_state = PDS_ST_WAIT;
      end
      PDS_ST_WAIT: begin
        if (nv_done) begin
          next_rsp_valid = 1'b1;
          next_state = PDS_ST_IDLE;
        end
      end
      default: begin
        next_state = PDS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PDS_ST_IDLE;
      suppress_word <= PDS_ZERO_WORD;
      rsp_valid <= 1'b0;
      rsp_code <= PDS_RES_OK;
      rsp_rdata <= PDS_ZERO_WORD;
      nv_write <= 1'b0;
      nv_index <= 16'h0000;
      nv_sub <= PDS_SUB_ZERO;
      nv_data <= PDS_ZERO_WORD;
      storage_suppress_mode <= 1'b0;
      req_busy <= 1'b0;
      for (int c = 0; c < CHANNELS; c++) begin
        out_obj[c] <= PDS_ZERO_WORD;
        for (int s = 0; s < SUBS; s++) begin
          param[c][s] <= PDS_ZERO_WORD;
        end
      end
    end else begin
      state <= next_state;
      suppress_word <= next_suppress_word;
      rsp_valid <= next_rsp_valid;
      rsp_code <= next_rsp_code;
      rsp_rdata <= next_rsp_rdata;
      nv_write <= next_nv_write;
      nv_index <= next_nv_index;
      nv_sub <= next_nv_sub;
      nv_data <= next_nv_data;
      // code word enables suppression, held while kept
      storage_suppress_mode <= next_suppress_word == PDS_SUPPRESS_CODE;
      req_busy <= next_state != PDS_ST_IDLE;
      out_obj <= next_out_obj;
      param <= next_param;
    end
  end

  logic [63:0] time_now;
  pds_time #(
    .TIME_WIDTH(TIME_WIDTH),
    .STEP_NS(PDS_CLK_PERIOD_NS)
  ) u_time (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .offset_valid(time_offset_valid),
    .offset_ns(time_offset_ns),
    .sys_time(time_now)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_time <= 64'h0000000000000000;
    end else begin
      sys_time <= time_now;
    end
  end

  sequence s_param_write;
    req_valid && req_write && is_param && state == PDS_ST_IDLE;
  endsequence

  a_commit_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_param_write and !storage_suppress_mode) |=> nv_write && nv_data == $past(req_wdata))
    else $error("write without suppression did not commit");

  a_suppress_skip: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_param_write and storage_suppress_mode) |=> !nv_write && rsp_valid)
    else $error("suppressed write reached storage");

  a_code_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && req_write && is_supp && state == PDS_ST_IDLE && req_wdata == PDS_SUPPRESS_CODE
    |=> storage_suppress_mode)
    else $error("code word did not enable suppression");

  a_mode_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    storage_suppress_mode && !(req_valid && req_write && is_supp && state == PDS_ST_IDLE)
    |=> storage_suppress_mode)
    else $error("suppression mode dropped while code kept");

  a_mode_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && req_write && is_supp && state == PDS_ST_IDLE && req_wdata != PDS_SUPPRESS_CODE
    |=> !storage_suppress_mode)
    else $error("changed code word left suppression on");

  a_read_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && req_write && (is_in || is_ident) && state == PDS_ST_IDLE
    |=> rsp_valid && rsp_code == PDS_RES_READ_ONLY)
    else $error("fixed entry accepted a write");

  // legacy and new range read same value
  a_mirror_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && !req_write && is_param && state == PDS_ST_IDLE
    |=> rsp_rdata == $past(param[chan][sub]))
    else $error("mirrored read returned wrong value");

  a_ident_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && !req_write && req_index == PDS_IDX_IDENT && req_sub == PDS_SUB_ONE && state == PDS_ST_IDLE
    |=> rsp_rdata == ID_VENDOR && rsp_code == PDS_RES_OK)
    else $error("identity read wrong");

  a_no_entry: assert property (@(posedge ref_clk) disable iff (!rst_b)
    req_valid && state == PDS_ST_IDLE && !(is_param || is_in || is_out || is_ident || is_supp)
    |=> rsp_code == PDS_RES_NO_ENTRY)
    else $error("missing entry not refused");
endmodule

// ==== tb/pds_nv_model.sv ====
// Non-volatile store model: takes commits and answers after a chosen delay
module pds_nv_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic nv_write,
  input wire logic [15:0] nv_index,
  input wire logic [7:0] nv_sub,
  input wire logic [31:0] nv_data,
  input wire logic [3:0] nv_delay,
  output logic nv_done,
  output int commits,
  output logic [55:0] last_commit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] wait_cnt;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_done <= 1'b0;
      wait_cnt <= 5'h00;
      commits <= 0;
      last_commit <= 56'h0;
    end else begin
      nv_done <= 1'b0;
      if (nv_write) begin
        wait_cnt <= {1'b0, nv_delay} + 5'h01;
        commits <= commits + 1;
        last_commit <= {nv_index, nv_sub, nv_data};
      end else if (wait_cnt == 5'h01) begin
        nv_done <= 1'b1;
        wait_cnt <= 5'h00;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
    end
  end
endmodule

// ==== tb/pds_dict_tb.sv ====
// Testbench for the parameter dictionary with system time
module pds_dict_tb import pds_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CH = 2;
  localparam int SB = 4;
  logic ref_clk = 0, rst_b = 0, req_valid = 0, req_write = 0, time_offset_valid = 0;
  logic [15:0] req_index = 16'h0000;
  logic [7:0] req_sub = 8'h00;
  logic [31:0] req_wdata = 32'h0;
  logic [63:0] time_offset_ns = 64'h0;
  logic [31:0] in_obj [CH];
  logic [31:0] out_obj [CH];
  logic rsp_valid, req_busy, nv_write, nv_done, storage_suppress_mode;
  logic [1:0] rsp_code;
  logic [31:0] rsp_rdata, nv_data;
  logic [15:0] nv_index;
  logic [7:0] nv_sub;
  logic [63:0] sys_time, t0;
  logic [3:0] nv_delay = 4'h0;
  logic [55:0] last_commit;
  logic [31:0] mem [int];
  int commits, failures = 0, tests_run = 0;
  bit sup = 0;
  pds_dict #(.CHANNELS(CH), .SUBS(SB)) u_pds_dict (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_sub(req_sub), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_rdata(rsp_rdata), .req_busy(req_busy), .nv_write(nv_write), .nv_index(nv_index),
    .nv_sub(nv_sub), .nv_data(nv_data), .nv_done(nv_done), .storage_suppress_mode(storage_suppress_mode),
    .in_obj(in_obj), .out_obj(out_obj), .time_offset_valid(time_offset_valid), .time_offset_ns(time_offset_ns),
    .sys_time(sys_time));
  pds_nv_model u_pds_nv_model (.ref_clk(ref_clk), .rst_b(rst_b), .nv_write(nv_write), .nv_index(nv_index),
    .nv_sub(nv_sub), .nv_data(nv_data), .nv_delay(nv_delay), .nv_done(nv_done), .commits(commits),
    .last_commit(last_commit));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    int n, key, c0;
    logic [1:0] ec;
    logic [31:0] er;
    bit known, cm, blk;
    n = 0;
    c0 = commits;
    key = int'({idx[15:12] == 4'h4 ? 4'h8 : idx[15:12], idx[11:0], sub});
    er = mem.exists(key) ? mem[key] : 32'h0;
    blk = idx[11:4] < CH && idx[3:0] == 4'h0;
    known = 1;
    cm = 0;
    ec = 2'h1;
    if (idx == PDS_IDX_IDENT && sub <= 8'h04) begin
      ec = w ? 2'h2 : 2'h0;
      known = sub == 8'h04;
      er = CH;
    end else if ((idx[15:12] == 4'h8 || idx[15:12] == 4'h4) && blk && sub < SB) begin
      ec = 2'h0;
      cm = w && !sup;
    end else if (idx[15:12] == 4'h6 && blk && sub == 8'h01) begin
      ec = w ? 2'h2 : 2'h0;
      er = in_obj[idx[7:4]];
    end else if ((idx[15:12] == 4'h7 && blk && sub == 8'h01) || (idx == PDS_IDX_SUPPRESS && sub == 8'h00)) begin
      ec = 2'h0;
    end
    if (w && ec == 2'h0) begin
      mem[key] = wd;
      if (idx == PDS_IDX_SUPPRESS) begin
        sup = wd == PDS_SUPPRESS_CODE;
      end
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_index <= idx;
    req_sub <= sub;
    req_wdata <= wd;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    check(req_busy, cm);
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      failures++;
      summarize();
    end else begin
      check(rsp_code, ec);
      if (ec == 2'h0 && known) begin
        check(rsp_rdata, er);
      end
      check(commits, c0 + cm);
      if (cm) begin
        check(last_commit, {key[23:0], wd});
      end
      check(req_busy, 1'b0);
      check(storage_suppress_mode, sup);
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    sup = 0;
    mem.delete();
    check(storage_suppress_mode, 1'b0);
    check(sys_time, 64'h0);
    check(out_obj[0], 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(sys_time, 64'd10);
  endtask
  initial begin
    void'($urandom(13781));
    for (int c = 0; c < CH; c++) begin
      in_obj[c] = $urandom;
    end
    do_reset();
    for (int s = 0; s < 6; s++) begin
      access(1'b0, PDS_IDX_IDENT, 8'(s), 32'h0);
    end
    access(1'b1, PDS_IDX_IDENT, 8'h04, 32'h1);
    for (int k = 0; k < 14; k++) begin
      nv_delay <= 4'($urandom_range(0, 12));
      access(1'($urandom), {$urandom_range(0, 1) ? 4'h8 : 4'h4, 4'h0, 4'($urandom_range(0, CH - 1)), 4'h0},
        8'($urandom_range(0, SB - 1)), $urandom);
    end
    for (int c = 0; c < CH; c++) begin
      for (int s = 0; s < SB; s++) begin
        access(1'b0, PDS_IDX_CHAN + 16'(c * 16), 8'(s), 32'h0);
        access(1'b0, PDS_IDX_LEGACY + 16'(c * 16), 8'(s), 32'h0);
      end
      access(1'b0, PDS_IDX_INPUT + 16'(c * 16), 8'h01, 32'h0);
      access(1'b1, PDS_IDX_INPUT + 16'(c * 16), 8'h01, 32'h5);
      access(1'b1, PDS_IDX_OUTPUT + 16'(c * 16), 8'h01, $urandom);
      check(out_obj[c], mem[int'({PDS_IDX_OUTPUT + 16'(c * 16), 8'h01})]);
    end
    for (int w = 0; w < 2; w++) begin
      access(1'(w), 16'h2000, 8'h00, 32'h7);
      access(1'(w), 16'h8001, 8'h00, 32'h7);
      access(1'(w), PDS_IDX_CHAN + 16'(CH * 16), 8'h00, 32'h7);
      access(1'(w), PDS_IDX_CHAN, 8'(SB), 32'h7);
      access(1'(w), 16'hFFFF, 8'hFF, 32'h7);
    end
    access(1'b1, PDS_IDX_SUPPRESS, 8'h00, PDS_SUPPRESS_CODE);
    for (int k = 0; k < 4; k++) begin
      access(1'b1, PDS_IDX_CHAN + 16'(k[0] * 16), 8'(k), $urandom);
    end
    access(1'b0, PDS_IDX_SUPPRESS, 8'h00, 32'h0);
    access(1'b1, PDS_IDX_SUPPRESS, 8'h00, 32'h12345679);
    access(1'b1, PDS_IDX_LEGACY, 8'h01, $urandom);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      #1;
      t0 = sys_time;
      @(posedge ref_clk);
      time_offset_ns <= k == 1 ? -64'd35 : 64'($urandom_range(0, 999));
      time_offset_valid <= k != 0;
      @(posedge ref_clk);
      time_offset_valid <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      check(sys_time - t0, 64'd100 + (k != 0 ? time_offset_ns : 64'h0));
    end
    access(1'b1, PDS_IDX_SUPPRESS, 8'h00, PDS_SUPPRESS_CODE);
    do_reset();
    summarize();
  end
endmodule
